/* hdl/bcst_pkg.sv */
package bcst_pkg;

  // ----------------------------------------------------------------
  // instruction layout
  // ----------------------------------------------------------------
  localparam int INSN_W        = 14;
  localparam int ADDR_W        = 7;
  localparam int BITSEL_W      = 3;
  localparam int DATA_W        = 8;
  localparam int ADDR_LSB      = 0;
  localparam int BITSEL_LSB    = 7;
  localparam int GROUP_LSB     = 12;
  localparam int SUBOP_LSB     = 10;
  localparam logic [1:0] GROUP_BIT   = 2'h1;  // upper bits 01
  localparam logic [1:0] SUBOP_CLEAR = 2'h0;
  localparam logic [1:0] SUBOP_SET   = 2'h1;
  localparam logic [1:0] SUBOP_TEST  = 2'h2;
  localparam logic [INSN_W-1:0] NOP_WORD  = 14'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 7'h00;
  localparam logic [DATA_W-1:0] DATA_RST  = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {BCST_OP_NONE, BCST_OP_CLEAR, BCST_OP_SET, BCST_OP_TEST} bcst_op_t;

  // register-file write request
  typedef struct packed {
    logic                   en;
    logic [ADDR_W-1:0]      addr;
    logic [DATA_W-1:0]      data;
  } bcst_wr_t;

endpackage : bcst_pkg

/* hdl/bcst_core.sv */
`timescale 1ns/1ps
`default_nettype none
module bcst_core
  import bcst_pkg::*;
(
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  // instruction stream, one word per cycle when valid
  input  wire logic                        insnValid,
  input  wire logic [bcst_pkg::INSN_W-1:0] insnWord,
  // register file read port, combinational data for the addressed register
  output logic      [bcst_pkg::ADDR_W-1:0] rdAddr,
  input  wire logic [bcst_pkg::DATA_W-1:0] rdData,
  // register file write request
  output bcst_pkg::bcst_wr_t               wrReq,
  // execution status
  output logic                             skipNext,
  output logic                             nopExec,
  output logic                             retired
);
  import bcst_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic bcst_op_t decodeOp(input logic [INSN_W-1:0] w);
    if (w[GROUP_LSB +: 2] != GROUP_BIT) return BCST_OP_NONE;
    unique case (w[SUBOP_LSB +: 2])
      SUBOP_CLEAR: return BCST_OP_CLEAR;
      SUBOP_SET:   return BCST_OP_SET;
      SUBOP_TEST:  return BCST_OP_TEST;
      default:     return BCST_OP_NONE;   // skip-if-set lives elsewhere
    endcase
  endfunction : decodeOp

  // group field of the live word, named so that the checks can see refused words
  logic [1:0] grpField;
  assign grpField = insnWord[GROUP_LSB +: 2];

  // the prefetched word is squashed while a skip is pending
  logic     skip_q;
  logic     fire;
  bcst_op_t op;
  logic [ADDR_W-1:0]   fAddr;
  logic [BITSEL_W-1:0] bSel;
  logic [DATA_W-1:0]   bitMask;
  logic                testBit;
  assign fire    = insnValid && !skip_q;
  assign op      = fire ? decodeOp(insnWord) : BCST_OP_NONE;
  assign fAddr   = insnWord[ADDR_LSB +: ADDR_W];
  assign bSel    = insnWord[BITSEL_LSB +: BITSEL_W];
  assign bitMask = DATA_W'(1) << bSel;
  assign testBit = |(rdData & bitMask);

  // read address presented combinationally from the live word
  assign rdAddr  = fAddr;

  // ----------------------------------------------------------------
  // execute
  // ----------------------------------------------------------------
  // read-modify-write; no status flag path exists in this block
  bcst_wr_t wr_d;
  always_comb begin
    wr_d      = '0;
    wr_d.addr = fAddr;
    wr_d.data = rdData;
    if (op == BCST_OP_CLEAR) begin
      wr_d.en   = 1'b1;
      wr_d.data = rdData & ~bitMask;
    end else if (op == BCST_OP_SET) begin
      wr_d.en   = 1'b1;
      wr_d.data = rdData | bitMask;
    end
  end

  // a test that reads a clear bit arms the squash of the next slot only;
  // a squashed test never arms another, so skips cannot chain
  logic skip_d;
  assign skip_d = (op == BCST_OP_TEST) && !testBit;

  // registered outputs; the write lands one cycle after decode
  // limitation: a test right after a write to the same register reads stale data
  // unless the register file forwards its pending write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrReq    <= '{en: 1'b0, addr: ADDR_RST, data: DATA_RST};
      skip_q   <= 1'b0;
      skipNext <= 1'b0;
      nopExec  <= 1'b0;
      retired  <= 1'b0;
    end else begin
      wrReq    <= wr_d;
      skip_q   <= skip_d;
      skipNext <= skip_d;
      nopExec  <= insnValid && skip_q;
      retired  <= fire;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // the chosen bit lands low in the write that follows a clear
  property p_clear_write;
    @(posedge clk_sys) disable iff (!rst_n)
      (op == BCST_OP_CLEAR) |=> wrReq.en && !wrReq.data[$past(bSel)] && wrReq.addr == $past(fAddr);
  endproperty
  a_clear_write: assert property (p_clear_write) else $error("clear did not clear bit");

  // the chosen bit lands high in the write that follows a set
  property p_set_write;
    @(posedge clk_sys) disable iff (!rst_n)
      (op == BCST_OP_SET) |=> wrReq.en && wrReq.data[$past(bSel)];
  endproperty
  a_set_write: assert property (p_set_write) else $error("set did not set bit");

  // neighbours of the chosen bit pass through a clear untouched
  property p_clear_keep;
    @(posedge clk_sys) disable iff (!rst_n)
      (op == BCST_OP_CLEAR) |=>
        (wrReq.data | (DATA_W'(1) << $past(bSel))) == ($past(rdData) | (DATA_W'(1) << $past(bSel)));
  endproperty
  a_clear_keep: assert property (p_clear_keep) else $error("clear disturbed other bits");

  // neighbours of the chosen bit pass through a set untouched
  property p_set_keep;
    @(posedge clk_sys) disable iff (!rst_n)
      (op == BCST_OP_SET) |=>
        (wrReq.data & ~(DATA_W'(1) << $past(bSel))) == ($past(rdData) & ~(DATA_W'(1) << $past(bSel)));
  endproperty
  a_set_keep: assert property (p_set_keep) else $error("set disturbed other bits");

  // the write goes back to the register named by the low field of the word
  property p_write_addr;
    @(posedge clk_sys) disable iff (!rst_n)
      (op == BCST_OP_CLEAR || op == BCST_OP_SET) |=> wrReq.addr == $past(insnWord[ADDR_LSB +: ADDR_W]);
  endproperty
  a_write_addr: assert property (p_write_addr) else $error("write address field wrong");

  // words outside the bit group only retire: no write and no skip
  property p_refused;
    @(posedge clk_sys) disable iff (!rst_n)
      (insnValid && grpField != GROUP_BIT) |=> !wrReq.en && !skipNext;
  endproperty
  a_refused: assert property (p_refused) else $error("foreign word acted");

  // an empty slot neither retires, squashes nor writes
  property p_idle_quiet;
    @(posedge clk_sys) disable iff (!rst_n)
      !insnValid |=> !retired && !nopExec && !wrReq.en;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("empty slot acted");

  // every valid slot that is not squashed retires exactly one cycle later
  property p_retire;
    @(posedge clk_sys) disable iff (!rst_n)
      (insnValid && !skipNext) |=> retired;
  endproperty
  a_retire: assert property (p_retire) else $error("slot did not retire in one cycle");

  // ----------------------------------------------------------------
  // checks: skip path
  // ----------------------------------------------------------------
  // a test reads only; it never writes back
  property p_test_nowrite;
    @(posedge clk_sys) disable iff (!rst_n) (op == BCST_OP_TEST) |=> !wrReq.en;
  endproperty
  a_test_nowrite: assert property (p_test_nowrite) else $error("test wrote register");

  // the test itself always retires one cycle later, even when it arms a skip
  property p_test_retire;
    @(posedge clk_sys) disable iff (!rst_n)
      (op == BCST_OP_TEST) |=> retired;
  endproperty
  a_test_retire: assert property (p_test_retire) else $error("test did not retire");

  // a clear bit arms the skip
  property p_skip_clear;
    @(posedge clk_sys) disable iff (!rst_n) (op == BCST_OP_TEST && !testBit) |=> skipNext;
  endproperty
  a_skip_clear: assert property (p_skip_clear) else $error("clear bit did not skip");

  // a set bit lets execution run on
  property p_noskip_set;
    @(posedge clk_sys) disable iff (!rst_n) (op == BCST_OP_TEST && testBit) |=> !skipNext;
  endproperty
  a_noskip_set: assert property (p_noskip_set) else $error("set bit skipped");

  // nothing but a test on a clear bit may arm a skip
  property p_skip_src;
    @(posedge clk_sys) disable iff (!rst_n)
      skipNext |-> $past(op == BCST_OP_TEST) && !$past(testBit);
  endproperty
  a_skip_src: assert property (p_skip_src) else $error("skip without a failing test");

  // the prefetched word runs as a no-op
  property p_squash;
    @(posedge clk_sys) disable iff (!rst_n)
      (skipNext && insnValid) |=> nopExec && !retired && !wrReq.en;
  endproperty
  a_squash: assert property (p_squash) else $error("prefetched word not squashed");

  // an empty slot after the test still uses up the skip
  property p_skip_bubble;
    @(posedge clk_sys) disable iff (!rst_n)
      (skipNext && !insnValid) |=> !skipNext && !nopExec && !retired;
  endproperty
  a_skip_bubble: assert property (p_skip_bubble) else $error("skip outlived an empty slot");

  // a no-op only ever stands in for a skipped word
  property p_nop_src;
    @(posedge clk_sys) disable iff (!rst_n)
      nopExec |-> $past(skipNext);
  endproperty
  a_nop_src: assert property (p_nop_src) else $error("no-op without a skip");

  // the skip costs exactly one extra slot
  property p_single_skip;
    @(posedge clk_sys) disable iff (!rst_n) skipNext |=> !skipNext;
  endproperty
  a_single_skip: assert property (p_single_skip) else $error("skip lasted over one slot");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  c_clear:  cover property (@(posedge clk_sys) disable iff (!rst_n) op == BCST_OP_CLEAR);
  c_set:    cover property (@(posedge clk_sys) disable iff (!rst_n) op == BCST_OP_SET);
  c_skip:   cover property (@(posedge clk_sys) disable iff (!rst_n) skipNext ##1 nopExec);
  c_pass:   cover property (@(posedge clk_sys) disable iff (!rst_n) op == BCST_OP_TEST && testBit);
  c_bubble: cover property (@(posedge clk_sys) disable iff (!rst_n) skipNext && !insnValid);

endmodule : bcst_core
`default_nettype wire

/* verification/bcst_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_clear_set_test_skip_tb_top;
  import bcst_pkg::*;

  // ------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------
  logic              clk_sys;
  logic              rst_n;
  logic              insnValid;
  logic [INSN_W-1:0] insnWord;
  logic [DATA_W-1:0] rdData;
  logic [ADDR_W-1:0] rdAddr;
  bcst_wr_t          wrReq;
  logic              skipNext;
  logic              nopExec;
  logic              retired;
  int                bad_count;
  int                total_checks;

  bcst_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .insnValid(insnValid), .insnWord(insnWord),
    .rdAddr(rdAddr), .rdData(rdData), .wrReq(wrReq), .skipNext(skipNext), .nopExec(nopExec),
    .retired(retired));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [INSN_W-1:0] word(input logic [1:0] s, input logic [2:0] b, input logic [6:0] f);
    return {GROUP_BIT, s, b, f};
  endfunction : word

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  // drive one slot at the falling edge; registered answers are settled one falling edge later
  task automatic slot(input logic [INSN_W-1:0] w, input logic [DATA_W-1:0] d);
    insnValid = 1'b1;
    insnWord  = w;
    rdData    = d;
    #1 chk(rdAddr, w[6:0]);
    @(negedge clk_sys);
  endtask : slot

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_clear_set();
    for (int b = 0; b < 8; b++) begin
      slot(word(SUBOP_CLEAR, b[2:0], 7'h7f), 8'hff);
      chk(wrReq, {1'b1, 7'h7f, 8'hff & ~(8'h01 << b)});
      chk({retired, skipNext, nopExec}, 3'h4);
      slot(word(SUBOP_SET, b[2:0], 7'h00), 8'h00);
      chk(wrReq, {1'b1, 7'h00, 8'h01 << b});
    end
    $display("test_clear_set done");
  endtask : test_clear_set

  // a test on a clear bit must squash the very next slot, even a write
  task automatic test_skip();
    for (int b = 0; b < 8; b++) begin
      slot(word(SUBOP_TEST, b[2:0], 7'h12), ~(8'h01 << b));
      chk({wrReq.en, retired, skipNext, nopExec}, 4'h6);
      slot(word(SUBOP_SET, 3'h0, 7'h12), 8'h00);
      chk({wrReq.en, retired, skipNext, nopExec}, 4'h1);
    end
    slot(word(SUBOP_CLEAR, 3'h0, 7'h12), 8'h01);
    chk(wrReq, {1'b1, 7'h12, 8'h00});
    $display("test_skip done");
  endtask : test_skip

  task automatic test_noskip();
    for (int b = 0; b < 8; b++) begin
      slot(word(SUBOP_TEST, b[2:0], 7'h33), 8'h01 << b);
      chk({wrReq.en, retired, skipNext, nopExec}, 4'h4);
      slot(word(SUBOP_SET, b[2:0], 7'h33), 8'h00);
      chk({wrReq.en, retired, skipNext, nopExec}, 4'hc);
    end
    slot(word(2'h3, 3'h0, 7'h05), 8'h00);
    chk({wrReq.en, retired, skipNext, nopExec}, 4'h4);
    $display("test_noskip done");
  endtask : test_noskip

  // an empty slot uses up a pending skip; foreign words only retire; reset drops a pending skip
  task automatic test_bubble_reset();
    slot(word(SUBOP_TEST, 3'h5, 7'h40), 8'h00);
    chk(skipNext, 1'b1);
    insnValid = 1'b0;
    @(negedge clk_sys);
    chk({wrReq.en, retired, skipNext, nopExec}, 4'h0);
    slot(word(SUBOP_SET, 3'h5, 7'h40), 8'h00);
    chk(wrReq, {1'b1, 7'h40, 8'h20});
    slot({2'h0, SUBOP_SET, 3'h5, 7'h40}, 8'h00);
    chk({wrReq.en, retired, skipNext, nopExec}, 4'h4);
    slot(word(SUBOP_TEST, 3'h1, 7'h40), 8'h00);
    chk(skipNext, 1'b1);
    rst_n = 1'b0;
    #1 chk({wrReq, retired, skipNext, nopExec}, 19'h0);
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    slot(word(SUBOP_SET, 3'h1, 7'h40), 8'h00);
    chk(wrReq, {1'b1, 7'h40, 8'h02});
    chk({retired, skipNext, nopExec}, 3'h4);
    $display("test_bubble_reset done");
  endtask : test_bubble_reset

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // watchdog: the whole run needs about sixty cycles, the limit allows some eight hundred
  initial begin
    #20000;
    bad_count++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    insnValid = 1'b0;
    insnWord = NOP_WORD;
    rdData = DATA_RST;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    test_clear_set();
    test_skip();
    test_noskip();
    test_bubble_reset();
    print_verdict();
  end
endmodule : bit_clear_set_test_skip_tb_top
`default_nettype wire
